// ===== design/lrx_core.sv
// lrx_core: per-port data link receive/ack, retry bookkeeping, tlp
// checking and routing into a descriptor fifo.
// assumes the media-access block delivers aligned 32-bit frame words.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - every tlp carries a 32-bit lcrc, checked over each received tlp frame
// - lcrc failure answers nak, good packet answers ack
// - transmitted packets stay in retry buffer until acknowledged
// - ack releases all stored packets with sequence at or below it
// - nak or replay timeout resends every unacknowledged packet, oldest first
// - each dllp carries a 16-bit crc, checked on receive
// - flow-control credits are initialised and updated only via dllps
// - extract header fields, check type and format are legal
// - illegal header or length mismatch is reported as malformed
// - digest bit set means the 32-bit ecrc is checked
// - config, completions, id messages route by bus number
// - memory and io route to the port whose window holds address
// - system messages route implicitly by message routing field
// - no matching port or id gives an unsupported request
// - training, deskew and scrambling live in the media-access block
// - traffic class zero always maps to virtual channel zero
module lrx_core
	import lrx_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   link_up_i,
	input  wire logic                   rx_valid_i,
	output logic                        rx_ready_o,
	input  wire logic                   rx_sop_i,
	input  wire logic                   rx_eop_i,
	input  wire logic                   rx_dllp_i,
	input  wire logic [31:0]            rx_data_i,
	input  wire logic [1:0]             own_port_i,
	input  wire logic [NP-1:0][31:0]    win_base_i,
	input  wire logic [NP-1:0][31:0]    win_limit_i,
	input  wire logic [NP-1:0][7:0]     bus_lo_i,
	input  wire logic [NP-1:0][7:0]     bus_hi_i,
	input  wire logic [7:0]             tc_vc1_i,
	output logic                        desc_valid_o,
	input  wire logic                   desc_ready_i,
	output logic [DESC_W-1:0]           desc_o,
	output logic                        dl_valid_o,
	output logic                        dl_nak_o,
	output logic [SEQ_W-1:0]            dl_seq_o,
	output logic [15:0]                 dl_crc_o,
	output logic                        err_lcrc_o,
	output logic                        err_dcrc_o,
	output logic                        err_malf_o,
	output logic                        fc_upd_o,
	output logic [2:0][7:0]             fc_hdr_o,
	output logic [2:0][11:0]            fc_data_o,
	input  wire logic                   tx_valid_i,
	input  wire logic [TAG_W-1:0]       tx_tag_i,
	output logic                        tx_ready_o,
	output logic                        snd_valid_o,
	output logic                        snd_replay_o,
	output logic [SEQ_W-1:0]            snd_seq_o,
	output logic [TAG_W-1:0]            snd_tag_o
);
	typedef struct packed {
		logic [SEQ_W-1:0]               rcv_seq;
		logic [SEQ_W-1:0]               seq;
		logic [31:0]                    lcrc;
		logic [31:0]                    ecrc;
		logic [31:0]                    w1;
		logic [31:0]                    w2;
		logic [31:0]                    h0;
		logic [31:0]                    h2;
		logic [31:0]                    h3;
		logic [10:0]                    cnt;
		logic                           in_tlp;
		logic                           dl_v;
		logic                           dl_nak;
		logic [SEQ_W-1:0]               dl_seq;
		logic [15:0]                    dl_crc;
		logic                           err_lcrc;
		logic                           err_dcrc;
		logic                           err_malf;
		logic                           fc_upd;
		logic [2:0][7:0]                fc_hdr;
		logic [2:0][11:0]               fc_data;
		lrx_tx_t                        st;
		logic [SEQ_W-1:0]               nxt_seq;
		logic [SEQ_W-1:0]               rp_seq;
		logic [3:0]                     rb_cnt;
		logic [7:0][TAG_W-1:0]          tags;
		logic [7:0]                     timer;
		logic                           tx_rdy;
		logic                           snd_v;
		logic                           snd_rp;
		logic [SEQ_W-1:0]               snd_seq;
		logic [TAG_W-1:0]               snd_tag;
	} lrx_st_t;

	function automatic logic [31:0] crc32(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--)
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? L_POLY : 32'h0);
		return r;
	endfunction

	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] r;
		r = D_INIT;
		for (int i = 31; i >= 0; i--)
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? D_POLY : 16'h0);
		return ~r;
	endfunction

	function automatic logic [NP-1:0] onehot(input logic [1:0] idx);
		return {{(NP-1){1'b0}}, 1'b1} << idx;
	endfunction

	lrx_st_t        s_r;
	lrx_st_t        n;
	logic           beat;
	logic           push_c;
	logic [DESC_W-1:0] desc_c;
	logic [31:0]    lc;
	logic [31:0]    ec;
	logic [SEQ_W-1:0] diff;
	logic [SEQ_W-1:0] ackv;
	logic [SEQ_W-1:0] old;
	logic [SEQ_W-1:0] off;
	logic [7:0]     dtype;
	logic           fifo_rdy;
	logic           ack_in;
	logic           nak_in;
	// header decode of the frame in flight
	logic           fmt4;
	logic           hasd;
	logic           td;
	logic [4:0]     ty;
	logic [2:0]     rrr;
	logic [9:0]     len;
	logic [2:0]     tc;
	logic [31:0]    addr_c;
	logic [7:0]     bus_c;
	logic [11:0]    exp_len;
	lrx_route_t     route_c;
	logic           legal_c;
	logic [NP-1:0]  a_hit;
	logic [NP-1:0]  i_hit;
	logic [NP-1:0]  impl_c;
	logic [NP-1:0]  dest_c;
	logic           local_c;

	assign fmt4 = s_r.h0[FMT_4DW];
	assign hasd = s_r.h0[FMT_DATA];
	assign td = s_r.h0[TD_BIT];
	assign ty = s_r.h0[TY_LSB +: 5];
	assign rrr = s_r.h0[TY_LSB +: 3];
	assign len = s_r.h0[9:0];
	assign tc = s_r.h0[TC_LSB +: 3];
	assign addr_c = fmt4 ? s_r.h3 : s_r.h2;
	assign bus_c = s_r.h2[BUS_LSB +: 8];
	// zero length field means 1024 dwords
	assign exp_len = 12'h2 + (fmt4 ? 12'h4 : 12'h3) + {11'h0, td}
		+ (hasd ? ((len == 10'h0) ? 12'h400 : {2'h0, len}) : 12'h0);

	always_comb begin
		route_c = RT_BAD;
		legal_c = 1'b0;
		case (ty)
			TY_MEM, TY_MEMLK: begin
				route_c = RT_ADDR;
				legal_c = 1'b1;
			end
			TY_IO: begin
				route_c = RT_ADDR;
				legal_c = !fmt4 && len == 10'h1;
			end
			TY_CFG0, TY_CFG1: begin
				route_c = RT_ID;
				legal_c = !fmt4 && len == 10'h1;
			end
			TY_CPL, TY_CPLLK: begin
				route_c = RT_ID;
				legal_c = !fmt4;
			end
			default: begin
				if (ty[4:3] == 2'b10) begin
					route_c = (rrr == R_ADDR) ? RT_ADDR : (rrr == R_ID) ? RT_ID : RT_IMPL;
					legal_c = fmt4;
				end
			end
		endcase
	end

	// address window match, bus range match
	for (genvar p = 0; p < NP; p++) begin : g_hit
		assign a_hit[p] = (2'(p) != own_port_i) && addr_c >= win_base_i[p]
			&& addr_c <= win_limit_i[p];
		assign i_hit[p] = (2'(p) != own_port_i) && bus_c >= bus_lo_i[p]
			&& bus_c <= bus_hi_i[p];
	end

	always_comb begin
		case (rrr)
			R_RC, R_GATHER: impl_c = (own_port_i != UP_PORT) ? onehot(UP_PORT) : '0;
			R_BCAST: impl_c = ~onehot(own_port_i);
			default: impl_c = '0;
		endcase
		case (route_c)
			RT_ADDR: dest_c = a_hit;
			RT_ID: dest_c = i_hit;
			RT_IMPL: dest_c = impl_c;
			default: dest_c = '0;
		endcase
		local_c = route_c == RT_IMPL && (rrr == R_LOCAL || own_port_i == UP_PORT);
	end

	always_comb begin
		n = s_r;
		n.dl_v = 1'b0;
		n.err_lcrc = 1'b0;
		n.err_dcrc = 1'b0;
		n.err_malf = 1'b0;
		n.fc_upd = 1'b0;
		n.snd_v = 1'b0;
		n.snd_rp = 1'b0;
		push_c = 1'b0;
		desc_c = '0;
		ack_in = 1'b0;
		nak_in = 1'b0;
		dtype = s_r.w1[31:24];
		// lcrc runs one word behind, the last word is the lcrc
		lc = crc32(s_r.lcrc, s_r.w1);
		// ecrc runs two words behind, it skips the sequence word
		ec = (s_r.cnt >= 11'h3) ? crc32(s_r.ecrc, s_r.w2) : s_r.ecrc;
		// modulo distance from the expected sequence
		diff = s_r.seq - s_r.rcv_seq;
		ackv = s_r.rcv_seq - 12'h1;
		// nothing is taken before the media-access block trains
		beat = rx_valid_i && rx_ready_o && link_up_i;
		if (beat && rx_sop_i) begin
			n.cnt = 11'h1;
			n.w1 = rx_data_i;
			n.w2 = '0;
			n.lcrc = L_INIT;
			n.ecrc = L_INIT;
			n.seq = rx_data_i[SEQ_W-1:0];
			n.in_tlp = !rx_dllp_i;
		end else if (beat) begin
			n.lcrc = lc;
			n.ecrc = ec;
			if (s_r.cnt == 11'h1)
				n.h0 = rx_data_i;
			if (s_r.cnt == 11'h3)
				n.h2 = rx_data_i;
			if (s_r.cnt == 11'h4)
				n.h3 = rx_data_i;
			n.w2 = s_r.w1;
			n.w1 = rx_data_i;
			if (s_r.cnt != 11'h7ff)
				n.cnt = s_r.cnt + 11'h1;
			if (rx_eop_i && s_r.in_tlp) begin
				n.dl_v = 1'b1;
				n.dl_nak = 1'b1;
				n.dl_seq = ackv;
				if (rx_data_i != ~lc) begin
					// corrupt packet is nak'd and dropped
					n.err_lcrc = 1'b1;
				end else if (diff == '0) begin
					n.dl_nak = 1'b0;
					n.dl_seq = s_r.rcv_seq;
					n.rcv_seq = s_r.rcv_seq + 12'h1;
					push_c = 1'b1;
					desc_c[DS_MALF] = !legal_c || ({1'b0, s_r.cnt} + 12'h1 != exp_len);
					n.err_malf = desc_c[DS_MALF];
					// digest checked against the word before lcrc
					desc_c[DS_ECRC] = td && !desc_c[DS_MALF] && s_r.w1 != ~ec;
					desc_c[DS_VC] = (tc != 3'h0) && tc_vc1_i[tc];
					desc_c[DS_RT +: 2] = route_c;
					desc_c[DS_LOCAL] = !desc_c[DS_MALF] && local_c;
					desc_c[NP-1:0] = desc_c[DS_MALF] ? '0 : dest_c;
					desc_c[DS_UR] = !desc_c[DS_MALF] && !local_c && dest_c == '0;
				end else if (diff[SEQ_W-1]) begin
					// earlier sequence is a duplicate, ack again
					n.dl_nak = 1'b0;
				end
				n.dl_crc = crc16({n.dl_nak ? DL_NAK : DL_ACK, 12'h0, n.dl_seq});
			end
			if (rx_eop_i && !s_r.in_tlp) begin
				if (rx_data_i[15:0] != crc16(s_r.w1)) begin
					n.err_dcrc = 1'b1;
				end else begin
					ack_in = dtype == DL_ACK;
					nak_in = dtype == DL_NAK;
					// credit limits come only from fc dllps
					if (dtype[7:6] != 2'b00 && dtype[5:4] != 2'b11) begin
						n.fc_hdr[dtype[5:4]] = s_r.w1[21:14];
						n.fc_data[dtype[5:4]] = s_r.w1[11:0];
						n.fc_upd = 1'b1;
					end
				end
			end
		end
		// modulo offset of the acknowledged sequence
		old = s_r.nxt_seq - {8'h0, s_r.rb_cnt};
		off = s_r.w1[SEQ_W-1:0] - old;
		if ((ack_in || nak_in) && off < {8'h0, s_r.rb_cnt}) begin
			// release everything up to and including it
			n.rb_cnt = s_r.rb_cnt - (off[3:0] + 4'h1);
			n.timer = '0;
		end
		old = s_r.nxt_seq - {8'h0, n.rb_cnt};
		// a replay overtaken by an ack skips released slots
		if (s_r.st == TX_REPLAY && (old - s_r.rp_seq) < 12'h800 && old != s_r.rp_seq)
			n.rp_seq = old;
		if (s_r.st == TX_REPLAY) begin
			// resend in order from the oldest
			if ((n.rp_seq - old) < {8'h0, n.rb_cnt}) begin
				n.snd_v = 1'b1;
				n.snd_rp = 1'b1;
				n.snd_seq = n.rp_seq;
				n.snd_tag = s_r.tags[n.rp_seq[2:0]];
				n.rp_seq = n.rp_seq + 12'h1;
			end else begin
				n.st = TX_RUN;
			end
		end else if (n.rb_cnt == 4'h0) begin
			n.timer = '0;
		end else if (nak_in || s_r.timer == REPLAY_CYC - 8'h1) begin
			// nak or timeout starts a replay
			n.st = TX_REPLAY;
			n.rp_seq = old;
			n.timer = '0;
		end else begin
			n.timer = s_r.timer + 8'h1;
		end
		if (tx_valid_i && s_r.tx_rdy) begin
			n.tags[s_r.nxt_seq[2:0]] = tx_tag_i;
			n.snd_v = 1'b1;
			n.snd_seq = s_r.nxt_seq;
			n.snd_tag = tx_tag_i;
			n.nxt_seq = s_r.nxt_seq + 12'h1;
			n.rb_cnt = n.rb_cnt + 4'h1;
			n.timer = '0;
		end
		// no new packet without a free retry slot
		n.tx_rdy = n.st == TX_RUN && n.rb_cnt < RB_DEPTH;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= n;
	end

	// back-pressure: a full fifo holds the link off
	lrx_fifo #(
		.W (DESC_W),
		.D (FIFO_D)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (push_c),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (desc_c),
		.out_valid_o (desc_valid_o),
		.out_ready_i (desc_ready_i),
		.out_data_o  (desc_o)
	);

	assign rx_ready_o = fifo_rdy;
	assign dl_valid_o = s_r.dl_v;
	assign dl_nak_o = s_r.dl_nak;
	assign dl_seq_o = s_r.dl_seq;
	assign dl_crc_o = s_r.dl_crc;
	assign err_lcrc_o = s_r.err_lcrc;
	assign err_dcrc_o = s_r.err_dcrc;
	assign err_malf_o = s_r.err_malf;
	assign fc_upd_o = s_r.fc_upd;
	assign fc_hdr_o = s_r.fc_hdr;
	assign fc_data_o = s_r.fc_data;
	assign tx_ready_o = s_r.tx_rdy;
	assign snd_valid_o = s_r.snd_v;
	assign snd_replay_o = s_r.snd_rp;
	assign snd_seq_o = s_r.snd_seq;
	assign snd_tag_o = s_r.snd_tag;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	lcrc_nak_a: assert property (err_lcrc_o |-> dl_valid_o && dl_nak_o)
		else $error("lcrc error without nak");
	good_ack_a: assert property (push_c |=> dl_valid_o && !dl_nak_o && dl_seq_o == $past(s_r.rcv_seq))
		else $error("good packet not acked");
	rb_hold_a: assert property (s_r.rb_cnt <= RB_DEPTH && (!tx_ready_o || s_r.rb_cnt < RB_DEPTH))
		else $error("retry buffer overrun");
	ack_purge_a: assert property (ack_in && !(tx_valid_i && s_r.tx_rdy) |=> s_r.rb_cnt <= $past(s_r.rb_cnt))
		else $error("ack grew retry buffer");
	replay_order_a: assert property (snd_replay_o && $past(snd_replay_o) |-> snd_seq_o == $past(snd_seq_o) + 12'h1)
		else $error("replay out of order");
	replay_timer_a: assert property (s_r.st == TX_RUN && s_r.rb_cnt != 4'h0 && s_r.timer == REPLAY_CYC - 8'h1 |=> s_r.st == TX_REPLAY)
		else $error("timeout missed");
	dcrc_drop_a: assert property (err_dcrc_o |-> !fc_upd_o)
		else $error("bad dllp used");
	ur_dest_a: assert property (push_c && desc_c[DS_UR] |-> desc_c[NP-1:0] == '0 && !desc_c[DS_MALF])
		else $error("ur with destination");
	tc0_vc0_a: assert property (push_c && tc == 3'h0 |-> !desc_c[DS_VC])
		else $error("tc0 left vc0");
	seq_step_a: assert property (push_c |=> s_r.rcv_seq == $past(s_r.rcv_seq) + 12'h1)
		else $error("sequence not advanced");

	replay_c: cover property (s_r.st == TX_RUN ##1 s_r.st == TX_REPLAY ##[1:8] snd_replay_o);
	nak_c: cover property (err_lcrc_o);
	ur_c: cover property (push_c && desc_c[DS_UR]);
	fc_c: cover property (fc_upd_o);
endmodule
`default_nettype wire

// ===== design/lrx_pkg.sv
// lrx_pkg: constants for the link receive, retry and routing block.
// assumes one core clock; header dwords are big-endian bit numbered.
package lrx_pkg;
	localparam int NP = 4;
	localparam int SEQ_W = 12;
	localparam int TAG_W = 8;
	localparam int DESC_W = 16;
	localparam int FIFO_D = 4;
	localparam logic [3:0] RB_DEPTH = 4'h8;
	localparam logic [1:0] UP_PORT = 2'h0;
	// link crc and dllp crc
	localparam logic [31:0] L_POLY = 32'h04c11db7;
	localparam logic [31:0] L_INIT = 32'hffffffff;
	localparam logic [15:0] D_POLY = 16'h100b;
	localparam logic [15:0] D_INIT = 16'hffff;
	// dllp types
	localparam logic [7:0] DL_ACK = 8'h00;
	localparam logic [7:0] DL_NAK = 8'h10;
	// header dword 0 fields, BUS_LSB is in dword 2
	localparam int FMT_DATA = 30;
	localparam int FMT_4DW = 29;
	localparam int TY_LSB = 24;
	localparam int TC_LSB = 20;
	localparam int TD_BIT = 15;
	localparam int BUS_LSB = 24;
	localparam logic [4:0] TY_MEM = 5'h00;
	localparam logic [4:0] TY_MEMLK = 5'h01;
	localparam logic [4:0] TY_IO = 5'h02;
	localparam logic [4:0] TY_CFG0 = 5'h04;
	localparam logic [4:0] TY_CFG1 = 5'h05;
	localparam logic [4:0] TY_CPL = 5'h0a;
	localparam logic [4:0] TY_CPLLK = 5'h0b;
	localparam logic [2:0] R_RC = 3'h0;
	localparam logic [2:0] R_ADDR = 3'h1;
	localparam logic [2:0] R_ID = 3'h2;
	localparam logic [2:0] R_BCAST = 3'h3;
	localparam logic [2:0] R_LOCAL = 3'h4;
	localparam logic [2:0] R_GATHER = 3'h5;
	// descriptor layout
	localparam int DS_VC = 4;
	localparam int DS_RT = 5;
	localparam int DS_UR = 7;
	localparam int DS_MALF = 8;
	localparam int DS_ECRC = 9;
	localparam int DS_LOCAL = 10;
	// replay timer
	localparam int CLK_NS = 20;
	localparam int REPLAY_NS = 1000;
	localparam logic [7:0] REPLAY_CYC = 8'(REPLAY_NS / CLK_NS);
	typedef enum logic [1:0] {
		RT_ADDR = 2'b00,
		RT_ID   = 2'b01,
		RT_IMPL = 2'b10,
		RT_BAD  = 2'b11
	} lrx_route_t;
	typedef enum logic {
		TX_RUN    = 1'b0,
		TX_REPLAY = 1'b1
	} lrx_tx_t;
endpackage

// ===== design/lrx_fifo.sv
// lrx_fifo: shift-register fifo, head word and flags held in flops.
// assumes a synchronous source and sink on clk_i.
`timescale 1ns/1ps
`default_nettype none
module lrx_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int CW = $clog2(D) + 1;
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [CW-1:0]       cnt;
		logic                ov;
		logic                ir;
	} lrx_fifo_t;
	lrx_fifo_t s_r;
	lrx_fifo_t s_nxt;
	logic      push;
	logic      pop;
	logic [CW-1:0] wr;
	always_comb begin
		s_nxt = s_r;
		pop = s_r.ov && out_ready_i;
		push = in_valid_i && s_r.ir;
		wr = s_r.cnt - CW'(pop);
		if (pop) begin
			for (int i = 0; i < D - 1; i++)
				s_nxt.mem[i] = s_r.mem[i+1];
		end
		if (push)
			s_nxt.mem[wr] = in_data_i;
		s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
		s_nxt.ov = s_nxt.cnt != '0;
		// ready drops as soon as the last slot is taken
		s_nxt.ir = s_nxt.cnt != CW'(D);
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign in_ready_o = s_r.ir;
	assign out_valid_o = s_r.ov;
	assign out_data_o = s_r.mem[0];
endmodule
`default_nettype wire

// ===== bench/lrx_peer.sv
// lrx_peer: link partner model, frames tlps and dllps, logs replies.
// assumes send is called just after a rising clk_i edge.
`timescale 1ns/1ps
`default_nettype none
module lrx_peer
	import lrx_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rdy_i,
	output logic                  vld_o,
	output logic                  sop_o,
	output logic                  eop_o,
	output logic                  dllp_o,
	output logic [31:0]           dat_o,
	input  wire logic             dl_valid_i,
	input  wire logic             dl_nak_i,
	input  wire logic [SEQ_W-1:0] dl_seq_i,
	input  wire logic [15:0]      dl_crc_i,
	input  wire logic             snd_valid_i,
	input  wire logic             snd_replay_i,
	input  wire logic [SEQ_W-1:0] snd_seq_i,
	input  wire logic [TAG_W-1:0] snd_tag_i
);
	logic [20:0]      sq[$];
	int               n_dl = 0;
	int               hangs = 0;
	logic             nak;
	logic [SEQ_W-1:0] seq;
	logic [15:0]      crc;
	initial begin
		vld_o = 1'b0;
		sop_o = 1'b0;
		eop_o = 1'b0;
		dllp_o = 1'b0;
		dat_o = 32'h0;
	end
	function automatic logic [31:0] c32(input logic [31:0] w[$]);
		logic [31:0] c;
		c = L_INIT;
		foreach (w[k])
			for (int i = 31; i >= 0; i--)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ w[k][i]) ? L_POLY : 32'h0);
		return ~c;
	endfunction
	function automatic logic [15:0] c16(input logic [31:0] w);
		logic [15:0] c;
		c = D_INIT;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? D_POLY : 16'h0);
		return ~c;
	endfunction
	task automatic send(input logic [31:0] w[$], input logic dl, input logic bad);
		int n;
		w.push_back(dl ? {16'h0, c16(w[0]) ^ {15'h0, bad}} : c32(w) ^ {31'h0, bad});
		foreach (w[k]) begin
			vld_o <= 1'b1;
			sop_o <= (k == 0);
			eop_o <= (k == w.size() - 1);
			dllp_o <= dl;
			dat_o <= w[k];
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (rdy_i !== 1'b1 && n < 200);
			if (n >= 200)
				hangs++;
		end
		vld_o <= 1'b0;
		sop_o <= 1'b0;
		eop_o <= 1'b0;
		// idle word inverted so a stale value never looks valid
		dat_o <= ~w[w.size()-1];
		// one idle edge, so a following frame never re-drives the strobes in one step
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (dl_valid_i === 1'b1) begin
			n_dl <= n_dl + 1;
			nak <= dl_nak_i;
			seq <= dl_seq_i;
			crc <= dl_crc_i;
		end
		if (snd_valid_i === 1'b1)
			sq.push_back({snd_replay_i, snd_seq_i, snd_tag_i});
	end
endmodule
`default_nettype wire

// ===== bench/lrx_core_bench.sv
// lrx_core_bench: scenarios for link receive, routing and retry.
// assumes lrx_peer on the link side; descriptor sink driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((e) !== (g)) begin \
		error_cnt++; \
		$display("BAD %s expected %0h seen %0h", nm, e, g); \
	end \
end
module lrx_core_bench
	import lrx_pkg::*;
;
	localparam logic [31:0] H1 = 32'h0000_000f;
	int error_cnt = 0;
	int n_checks = 0;
	logic clk_i, rst_n_i, link_up_i, rx_valid_i, rx_ready_o, rx_sop_i, rx_eop_i, rx_dllp_i;
	logic [31:0] rx_data_i;
	logic [1:0] own_port_i;
	logic [NP-1:0][31:0] win_base_i, win_limit_i;
	logic [NP-1:0][7:0] bus_lo_i, bus_hi_i;
	logic [7:0] tc_vc1_i;
	logic desc_valid_o, desc_ready_i, dl_valid_o, dl_nak_o, err_lcrc_o, err_dcrc_o, err_malf_o;
	logic [DESC_W-1:0] desc_o;
	logic [SEQ_W-1:0] dl_seq_o, snd_seq_o;
	logic [15:0] dl_crc_o;
	logic fc_upd_o, tx_valid_i, tx_ready_o, snd_valid_o, snd_replay_o;
	logic [2:0][7:0] fc_hdr_o;
	logic [2:0][11:0] fc_data_o;
	logic [TAG_W-1:0] tx_tag_i, snd_tag_o;
	logic [3:0] seen = 4'h0;
	lrx_core lrx_core_i (.clk_i, .rst_n_i, .link_up_i, .rx_valid_i, .rx_ready_o, .rx_sop_i,
		.rx_eop_i, .rx_dllp_i, .rx_data_i, .own_port_i, .win_base_i, .win_limit_i, .bus_lo_i,
		.bus_hi_i, .tc_vc1_i, .desc_valid_o, .desc_ready_i, .desc_o, .dl_valid_o, .dl_nak_o,
		.dl_seq_o, .dl_crc_o, .err_lcrc_o, .err_dcrc_o, .err_malf_o, .fc_upd_o, .fc_hdr_o,
		.fc_data_o, .tx_valid_i, .tx_tag_i, .tx_ready_o, .snd_valid_o, .snd_replay_o,
		.snd_seq_o, .snd_tag_o);
	lrx_peer lrx_peer_i (.clk_i, .rdy_i(rx_ready_o), .vld_o(rx_valid_i), .sop_o(rx_sop_i),
		.eop_o(rx_eop_i), .dllp_o(rx_dllp_i), .dat_o(rx_data_i), .dl_valid_i(dl_valid_o),
		.dl_nak_i(dl_nak_o), .dl_seq_i(dl_seq_o), .dl_crc_i(dl_crc_o), .snd_valid_i(snd_valid_o),
		.snd_replay_i(snd_replay_o), .snd_seq_i(snd_seq_o), .snd_tag_i(snd_tag_o));
	// sticky: lcrc, dllp crc, malformed, credit update pulses
	always @(posedge clk_i)
		seen <= seen | {fc_upd_o === 1'b1, err_malf_o === 1'b1, err_dcrc_o === 1'b1,
			err_lcrc_o === 1'b1};
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (s !== 1'b1 && n < 200);
		if (n >= 200) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic frame(input logic [31:0] w[$], input logic dl, input logic bad);
		lrx_peer_i.send(w, dl, bad);
		if (lrx_peer_i.hangs != 0) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic exp_dl(input int n0, input logic nk, input logic [SEQ_W-1:0] s);
		for (int n = 0; n < 20 && lrx_peer_i.n_dl == n0; n++)
			@(posedge clk_i);
		`CHK("dl_count", n0 + 1, lrx_peer_i.n_dl)
		`CHK("dl_nak", nk, lrx_peer_i.nak)
		`CHK("dl_seq", s, lrx_peer_i.seq)
		`CHK("dl_crc", lrx_peer_i.c16({nk ? DL_NAK : DL_ACK, 12'h0, s}), lrx_peer_i.crc)
	endtask
	task automatic get_desc(input logic [DESC_W-1:0] m, input logic [DESC_W-1:0] e);
		desc_ready_i <= 1'b1;
		wait_hi(desc_valid_o);
		`CHK("desc", e, desc_o & m)
		desc_ready_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic t_route();
		logic [31:0] q[$];
		int n0;
		n0 = lrx_peer_i.n_dl;
		// four packets with the sink stalled fill the queue
		frame({32'h0, 32'h4000_0001, H1, 32'h2000_0010, 32'h1}, 1'b0, 1'b0);
		frame({32'h1, 32'h0010_0001, H1, 32'h0000_0100}, 1'b0, 1'b0);
		frame({32'h2, 32'h0400_0001, H1, 32'h3500_0000}, 1'b0, 1'b0);
		frame({32'h3, 32'h0000_0001, H1, 32'h8000_0000}, 1'b0, 1'b0);
		repeat (4) @(posedge clk_i);
		`CHK("rx_ready_full", 1'b0, rx_ready_o)
		`CHK("ack_count", n0 + 4, lrx_peer_i.n_dl)
		`CHK("ack_seq", 12'h3, lrx_peer_i.seq)
		get_desc(16'hffff, 16'h0004);
		get_desc(16'hffff, 16'h0011);
		get_desc(16'hffff, 16'h0028);
		get_desc(16'hffff, 16'h0080);
		frame({32'h4, 32'h3300_0000, H1, 32'h0, 32'h0}, 1'b0, 1'b0);
		get_desc(16'hffff, 16'h004d);
		frame({32'h5, 32'h4000_0002, H1, 32'h2000_0000, 32'h1}, 1'b0, 1'b0);
		get_desc(16'h0100, 16'h0100);
		`CHK("malf_pulse", 1'b1, seen[2])
		q = {32'h6, 32'h4000_8001, H1, 32'h2000_0020, 32'h5};
		q.push_back(lrx_peer_i.c32(q[1:4]) ^ 32'h1);
		frame(q, 1'b0, 1'b0);
		get_desc(16'hffff, 16'h0204);
		$display("test route done");
	endtask
	task automatic t_link();
		int n0;
		n0 = lrx_peer_i.n_dl;
		`CHK("lcrc_idle", 1'b0, seen[0])
		frame({32'h7, 32'h4000_0001, H1, 32'h2000_0000, 32'h9}, 1'b0, 1'b1);
		exp_dl(n0, 1'b1, 12'h6);
		`CHK("lcrc_pulse", 1'b1, seen[0])
		frame({32'h3, 32'h4000_0001, H1, 32'h2000_0000, 32'h9}, 1'b0, 1'b0);
		exp_dl(n0 + 1, 1'b0, 12'h6);
		repeat (6) @(posedge clk_i);
		`CHK("no_desc", 1'b0, desc_valid_o)
		frame({32'h7, 32'h4000_0001, H1, 32'h2000_0000, 32'h9}, 1'b0, 1'b0);
		exp_dl(n0 + 2, 1'b0, 12'h7);
		get_desc(16'hffff, 16'h0004);
		// words offered while the link is down must be ignored
		link_up_i <= 1'b0;
		frame({32'h8, 32'h4000_0001, H1, 32'h2000_0000, 32'h9}, 1'b0, 1'b0);
		repeat (4) @(posedge clk_i);
		`CHK("link_down_dl", n0 + 3, lrx_peer_i.n_dl)
		`CHK("link_down_desc", 1'b0, desc_valid_o)
		link_up_i <= 1'b1;
		$display("test link done");
	endtask
	task automatic t_fc();
		for (int c = 0; c < 3; c++)
			frame({{8'h40 | 8'(c << 4), 2'b00, 8'(8'h20 + c), 2'b00, 12'(12'h340 + c)}}, 1'b1, 1'b0);
		repeat (4) @(posedge clk_i);
		`CHK("fc_pulse", 1'b1, seen[3])
		for (int c = 0; c < 3; c++) begin
			`CHK("fc_hdr", 8'(8'h20 + c), fc_hdr_o[c])
			`CHK("fc_data", 12'(12'h340 + c), fc_data_o[c])
		end
		$display("test credit done");
	endtask
	task automatic t_retry();
		tx_valid_i <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			tx_tag_i <= 8'ha0 + 8'(i);
			wait_hi(tx_ready_o);
		end
		tx_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 3; i++)
			`CHK("send", {1'b0, 12'(i), 8'ha0 + 8'(i)}, lrx_peer_i.sq[i])
		frame({{DL_ACK, 24'h0}}, 1'b1, 1'b0);
		frame({{DL_NAK, 24'h0}}, 1'b1, 1'b0);
		repeat (6) @(posedge clk_i);
		`CHK("replay_n", 5, lrx_peer_i.sq.size())
		`CHK("replay1", {1'b1, 12'h1, 8'ha1}, lrx_peer_i.sq[3])
		`CHK("replay2", {1'b1, 12'h2, 8'ha2}, lrx_peer_i.sq[4])
		// no answer for the replay timeout resends both again
		repeat (55) @(posedge clk_i);
		`CHK("timer_n", 7, lrx_peer_i.sq.size())
		`CHK("timer1", {1'b1, 12'h1, 8'ha1}, lrx_peer_i.sq[5])
		frame({{DL_ACK, 24'h2}}, 1'b1, 1'b1);
		repeat (2) @(posedge clk_i);
		`CHK("dcrc_pulse", 1'b1, seen[1])
		frame({{DL_ACK, 24'h2}}, 1'b1, 1'b0);
		repeat (80) @(posedge clk_i);
		`CHK("purged", 7, lrx_peer_i.sq.size())
		`CHK("tx_ready", 1'b1, tx_ready_o)
		$display("test retry done");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		rst_n_i = 1'b0;
		link_up_i = 1'b1;
		own_port_i = 2'h1;
		tc_vc1_i = 8'h03;
		desc_ready_i = 1'b0;
		tx_valid_i = 1'b0;
		tx_tag_i = 8'h0;
		for (int p = 0; p < NP; p++) begin
			win_base_i[p] = 32'(p) << 28;
			win_limit_i[p] = (32'(p) << 28) | 32'h0fff_ffff;
			bus_lo_i[p] = 8'(p * 16);
			bus_hi_i[p] = 8'(p * 16 + 15);
		end
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_route();
		t_link();
		t_fc();
		t_retry();
		print_verdict();
	end
endmodule
`default_nettype wire
